// ===== src/fse_pkg.sv
// constants, commands and types shared by the flash sequencer host
package fse_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int AW = 20;
  localparam logic [19:0] ADDR_UNLK1 = 20'h00555;
  localparam logic [19:0] ADDR_UNLK2 = 20'h002AA;
  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_UNLK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_ESETUP = 8'h80;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_SERASE = 8'h30;
  localparam logic [7:0] CMD_SUSP = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [2:0] LAST_PROG = 3'h3;
  localparam logic [2:0] LAST_ERASE = 3'h5;
  localparam logic [2:0] LEN_ERASE = 3'h6;
  // ---------------------------------------------------------------
  // status byte positions on data_bus
  // ---------------------------------------------------------------
  localparam int BIT_DATA_POLL = 7;
  localparam int BIT_TOGGLE = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_ERASE_START = 3;
  localparam int BIT_ERASE_TOGGLE = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 45;
  localparam int T_SUSP_US = 20;
  localparam int SYNC_STG = 2;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = ACC_CYC + SYNC_STG;
  localparam int SUSP_CYC = (T_SUSP_US * 1000 + CLK_NS - 1) / CLK_NS;
  // ---------------------------------------------------------------
  // user operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_SUSP, OP_RESUME, OP_RESET, OP_POLL
  } fse_op_t;
endpackage

// ===== src/fse_cyc_if.sv
// single bus cycle request and answer between sequencer and pin engine
`timescale 1ns/1ps
interface fse_cyc_if #(parameter int AW = fse_pkg::AW);
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// ===== src/fse_cyc_eng.sv
// pin engine: one read or write cycle on the flash strobes per request
`timescale 1ns/1ps
module fse_cyc_eng #(
  parameter int AW = fse_pkg::AW
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  fse_cyc_if.eng cy,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [AW-1:0] o_addr,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe_n,
  input wire logic [7:0] i_dq
);
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fse_ph_t;
  typedef struct packed {
    fse_ph_t ph;
    logic [2:0] cnt;
    logic wr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [AW-1:0] addr;
    logic [7:0] dq_out;
    logic [7:0] rdata;
    logic done;
    logic [7:0] s1;
    logic [7:0] s2;
  } fse_eng_t;

  localparam logic [2:0] WP_LAST = 3'(fse_pkg::WP_CYC - 1);
  localparam logic [2:0] RD_LAST = 3'(fse_pkg::RD_CYC - 1);

  fse_eng_t r_reg;
  fse_eng_t r_next;

  // ---------------------------------------------------------------
  // cycle sequencing
  // ---------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.s1 = i_dq;
    r_next.s2 = r_reg.s1;
    unique case (r_reg.ph)
      PH_IDLE: begin
        if (cy.req) begin
          r_next.ph = PH_SETUP;
          r_next.wr = cy.wr;
          r_next.addr = cy.addr;
          r_next.dq_out = cy.wdata;
          r_next.ce_n = 1'b0;
          r_next.dq_oe_n = !cy.wr;
          r_next.cnt = 3'h0;
        end
      end
      PH_SETUP: begin
        r_next.ph = PH_STROBE;
        r_next.we_n = !r_reg.wr;
        r_next.oe_n = r_reg.wr;
      end
      PH_STROBE: begin
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_reg.cnt == (r_reg.wr ? WP_LAST : RD_LAST)) begin
          // write data latches on this rising edge; read samples the synced bus
          r_next.ph = PH_HOLD;
          r_next.we_n = 1'b1;
          r_next.oe_n = 1'b1;
          if (!r_reg.wr) begin
            r_next.rdata = r_reg.s2;
          end
        end
      end
      PH_HOLD: begin
        r_next.ph = PH_IDLE;
        r_next.ce_n = 1'b1;
        r_next.dq_oe_n = 1'b1;
        r_next.done = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg <= '{ph: PH_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign cy.done = r_reg.done;
  assign cy.rdata = r_reg.rdata;
  assign o_ce_n = r_reg.ce_n;
  assign o_oe_n = r_reg.oe_n;
  assign o_we_n = r_reg.we_n;
  assign o_addr = r_reg.addr;
  assign o_dq_out = r_reg.dq_out;
  assign o_dq_oe_n = r_reg.dq_oe_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_we_pulse_width: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $fell(o_we_n) |-> (!o_we_n && !o_ce_n && !o_dq_oe_n) [*2] ##1 o_we_n)
    else $error("write strobe width wrong");
  a_oe_read_width: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $fell(o_oe_n) |-> (!o_oe_n && o_dq_oe_n) [*5] ##1 (o_oe_n ##1 cy.done))
    else $error("read strobe width wrong");
endmodule

// ===== src/fse_host.sv
// host sequencer for flash sector erase, suspend, resume, program and status polling
// Function
// RQ1: sector erase is sent as six writes: two unlocks, setup, two unlocks, sector+30h
// RQ2: device starts erasing on the first 30h; only one sector at a time
// RQ3: host never starts another sector erase before the running one finishes; code clears erasing if a program fails in suspend, then accepts OP_ERASE
// RQ4: during sector erase device accepts only suspend, ignoring other commands
// RQ5: after erase completes device returns to array read, addresses unlatched
// RQ6: suspend acts only during sector erase; its address is don't care
// RQ7: device finishes suspending within 20 us after suspend is accepted
// RQ8: while suspended other sectors read and program normally; erasing sectors give status
// RQ9: resume continues erase; repeated resumes ignored; suspend allowed again afterwards
// RQ10: during program data_poll_bit reads inverted, true after completion
// RQ11: during erase data_poll_bit reads 0, then 1 on completion
// RQ12: host polls only at an address inside the sector being programmed or erased
// RQ13: near completion only data_poll_bit may be valid; next read fully valid
// RQ14: ready_busy_n is pulled low while program or erase runs
// RQ15: ready_busy_n released when ready for reads, suspended, or in standby
// RQ16: toggle_bit inverts on every read while program or erase runs
// RQ17: program to protected sector toggles about 2 us, data unchanged
// RQ18: erase of only protected sectors toggles about 100 us, then read mode
// RQ19: timeout_error_bit goes 1 when program or erase exceeds its pulse limit
// RQ20: programming never turns 0 into 1; attempts halt and raise timeout_error_bit
// RQ21: after timeout_error_bit the host writes reset to return to array read
// RQ22: erase_start_bit goes from 0 to 1 when sector erase actually begins
// RQ23: one reset write, any address, returns to array read when not busy
// RQ24: erase_toggle_bit inverts on reads inside sectors selected for erase
// RQ25: suspend is B0h to any address, resume is 30h to any address
// RQ26: busy status byte carries the five status bits at their data_bus positions
`timescale 1ns/1ps
module fse_host #(
  parameter int AW = fse_pkg::AW
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_op_valid,
  input wire fse_pkg::fse_op_t i_op,
  input wire logic [AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic o_op_ready,
  output logic o_op_done,
  output logic o_op_err,
  output logic [7:0] o_rdata,
  output logic o_erase_active,
  output logic o_erase_susp,
  output logic o_dev_busy,
  input wire logic i_ready_busy_n,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic [AW-1:0] o_addr,
  output logic [7:0] o_dq_out,
  output logic o_dq_oe_n,
  input wire logic [7:0] i_dq
);
  typedef enum logic [2:0] {M_IDLE, M_WR, M_RD, M_POLL1, M_POLL2, M_SUSPW, M_FAILRST} fse_st_t;
  typedef struct packed {
    fse_st_t st;
    fse_pkg::fse_op_t op;
    logic [2:0] step;
    logic [AW-1:0] uaddr;
    logic [7:0] uwdata;
    logic [AW-1:0] sect;
    logic req;
    logic wr;
    logic [AW-1:0] baddr;
    logic [7:0] bdata;
    logic [7:0] rdata;
    logic tog;
    logic chk;
    logic err;
    logic done;
    logic ready;
    logic erasing;
    logic susp;
    logic [9:0] cnt;
    logic [2:0] wcnt;
    logic rb1;
    logic rb2;
    logic dbusy;
  } fse_host_t;

  localparam logic [9:0] SUSP_LAST = 10'(fse_pkg::SUSP_CYC - 1);
  localparam logic [AW-1:0] A_U1 = AW'(fse_pkg::ADDR_UNLK1);
  localparam logic [AW-1:0] A_U2 = AW'(fse_pkg::ADDR_UNLK2);

  fse_host_t r_reg;
  fse_host_t r_next;
  fse_cyc_if #(.AW(AW)) cy ();

  // unlock sequences of program and sector erase, one word per step
  function automatic logic [AW+7:0] seq_word(input fse_pkg::fse_op_t op, input logic [2:0] step,
                                             input logic [AW-1:0] a, input logic [7:0] d);
    logic is_prog;
    is_prog = (op == fse_pkg::OP_PROG);
    unique case (step)
      3'h0: seq_word = {A_U1, fse_pkg::CMD_UNLK1};
      3'h1: seq_word = {A_U2, fse_pkg::CMD_UNLK2};
      3'h2: seq_word = {A_U1, is_prog ? fse_pkg::CMD_PROG : fse_pkg::CMD_ESETUP};
      3'h3: seq_word = is_prog ? {a, d} : {A_U1, fse_pkg::CMD_UNLK1};
      3'h4: seq_word = {A_U2, fse_pkg::CMD_UNLK2};
      default: seq_word = {a, fse_pkg::CMD_SERASE};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    logic legal;
    logic [AW+7:0] w;
    logic toggling;
    legal = 1'b0;
    w = '0;
    toggling = 1'b0;
    r_next = r_reg;
    r_next.req = 1'b0;
    r_next.done = 1'b0;
    r_next.rb1 = i_ready_busy_n;
    r_next.rb2 = r_reg.rb1;
    r_next.dbusy = !r_reg.rb2;
    if (r_reg.done) begin
      r_next.err = 1'b0;
    end
    if (cy.done && r_reg.wr) begin
      r_next.wcnt = r_reg.wcnt + 3'h1;
    end
    unique case (r_reg.st)
      M_IDLE: begin
        if (i_op_valid) begin
          unique case (i_op)
            fse_pkg::OP_READ: legal = 1'b1;
            fse_pkg::OP_PROG: legal = !r_reg.erasing || r_reg.susp;
            fse_pkg::OP_ERASE: legal = !r_reg.erasing; // RQ3
            fse_pkg::OP_SUSP: legal = r_reg.erasing && !r_reg.susp; // RQ6
            fse_pkg::OP_RESUME: legal = r_reg.susp; // RQ9
            fse_pkg::OP_RESET: legal = !r_reg.erasing; // RQ23
            fse_pkg::OP_POLL: legal = r_reg.erasing && !r_reg.susp;
            default: legal = 1'b0;
          endcase
          r_next.op = i_op;
          r_next.uaddr = i_addr;
          r_next.uwdata = i_wdata;
          r_next.step = 3'h0;
          r_next.chk = 1'b0;
          r_next.wcnt = 3'h0;
          r_next.req = legal;
          if (!legal) begin
            r_next.done = 1'b1;
            r_next.err = 1'b1;
          end else begin
            unique case (i_op)
              fse_pkg::OP_READ: begin
                r_next.st = M_RD;
                r_next.wr = 1'b0;
                r_next.baddr = i_addr;
              end
              fse_pkg::OP_POLL: begin
                r_next.st = M_POLL1;
                r_next.wr = 1'b0;
                r_next.baddr = r_reg.sect; // RQ12
              end
              fse_pkg::OP_PROG, fse_pkg::OP_ERASE: begin
                w = seq_word(i_op, 3'h0, i_addr, i_wdata);
                r_next.st = M_WR;
                r_next.wr = 1'b1;
                r_next.baddr = w[AW+7:8];
                r_next.bdata = w[7:0];
              end
              default: begin
                r_next.st = M_WR;
                r_next.wr = 1'b1;
                r_next.baddr = i_addr;
                // single-byte commands, any address
                if (i_op == fse_pkg::OP_SUSP) begin
                  r_next.bdata = fse_pkg::CMD_SUSP; // RQ25
                end else if (i_op == fse_pkg::OP_RESUME) begin
                  r_next.bdata = fse_pkg::CMD_RESUME; // RQ25
                end else begin
                  r_next.bdata = fse_pkg::CMD_RESET; // RQ23
                end
              end
            endcase
          end
        end
      end
      M_WR: begin
        if (cy.done) begin
          if ((r_reg.op == fse_pkg::OP_PROG && r_reg.step != fse_pkg::LAST_PROG) ||
              (r_reg.op == fse_pkg::OP_ERASE && r_reg.step != fse_pkg::LAST_ERASE)) begin
            w = seq_word(r_reg.op, r_reg.step + 3'h1, r_reg.uaddr, r_reg.uwdata); // RQ1
            r_next.step = r_reg.step + 3'h1;
            r_next.req = 1'b1;
            r_next.baddr = w[AW+7:8];
            r_next.bdata = w[7:0];
          end else if (r_reg.op == fse_pkg::OP_PROG) begin
            // poll at the programmed address itself
            r_next.st = M_POLL1;
            r_next.req = 1'b1;
            r_next.wr = 1'b0;
            r_next.baddr = r_reg.uaddr; // RQ12
          end else if (r_reg.op == fse_pkg::OP_SUSP) begin
            r_next.st = M_SUSPW;
            r_next.cnt = 10'h000;
          end else begin
            r_next.st = M_IDLE;
            r_next.done = 1'b1;
            if (r_reg.op == fse_pkg::OP_ERASE) begin
              // erase is running from the 30h write on; only one sector is held
              r_next.erasing = 1'b1; // RQ2
              r_next.sect = r_reg.uaddr;
            end
            if (r_reg.op == fse_pkg::OP_RESUME) begin
              r_next.susp = 1'b0; // RQ9
            end
          end
        end
      end
      M_RD: begin
        if (cy.done) begin
          r_next.st = M_IDLE;
          r_next.done = 1'b1;
          r_next.rdata = cy.rdata;
        end
      end
      M_POLL1: begin
        if (cy.done) begin
          r_next.st = M_POLL2;
          r_next.tog = cy.rdata[fse_pkg::BIT_TOGGLE];
          r_next.req = 1'b1;
        end
      end
      M_POLL2: begin
        if (cy.done) begin
          toggling = cy.rdata[fse_pkg::BIT_TOGGLE] != r_reg.tog; // RQ16
          r_next.rdata = cy.rdata;
          if (!toggling) begin
            r_next.st = M_IDLE;
            r_next.done = 1'b1;
            if (r_reg.op == fse_pkg::OP_POLL) begin
              r_next.erasing = 1'b0; // RQ5
            end
          end else if (cy.rdata[fse_pkg::BIT_TIMEOUT] && r_reg.chk) begin
            // still toggling after the error bit rose: failed, reset the device
            r_next.st = M_FAILRST; // RQ21
            r_next.req = 1'b1;
            r_next.wr = 1'b1;
            r_next.bdata = fse_pkg::CMD_RESET; // RQ21
          end else begin
            // error bit may rise just as toggling stops; look twice more
            r_next.chk = cy.rdata[fse_pkg::BIT_TIMEOUT]; // RQ19
            r_next.st = M_POLL1;
            r_next.req = 1'b1;
          end
        end
      end
      M_SUSPW: begin
        r_next.cnt = r_reg.cnt + 10'h001;
        if (r_reg.cnt == SUSP_LAST) begin
          r_next.st = M_IDLE; // RQ7
          r_next.done = 1'b1;
          r_next.susp = 1'b1;
        end
      end
      M_FAILRST: begin
        if (cy.done) begin
          r_next.st = M_IDLE;
          r_next.done = 1'b1;
          r_next.err = 1'b1;
          r_next.erasing = 1'b0;
          r_next.susp = 1'b0;
        end
      end
    endcase
    r_next.ready = (r_next.st == M_IDLE);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_reg <= '{st: M_IDLE, op: fse_pkg::OP_READ, ready: 1'b1, rb1: 1'b1, rb2: 1'b1,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign cy.req = r_reg.req;
  assign cy.wr = r_reg.wr;
  assign cy.addr = r_reg.baddr;
  assign cy.wdata = r_reg.bdata;
  assign o_op_ready = r_reg.ready;
  assign o_op_done = r_reg.done;
  assign o_op_err = r_reg.err;
  assign o_rdata = r_reg.rdata;
  assign o_erase_active = r_reg.erasing;
  assign o_erase_susp = r_reg.susp;
  assign o_dev_busy = r_reg.dbusy;

  fse_cyc_eng #(.AW(AW)) u_eng (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .cy(cy),
    .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_addr(o_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe_n(o_dq_oe_n),
    .i_dq(i_dq)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_erase_six_writes: assert property ( // RQ1
    r_reg.done && r_reg.op == fse_pkg::OP_ERASE && !r_reg.err |-> r_reg.wcnt == fse_pkg::LEN_ERASE)
    else $error("sector erase not six writes");
  a_erase_starts: assert property ( // RQ2
    r_reg.done && r_reg.op == fse_pkg::OP_ERASE && !r_reg.err |-> r_reg.erasing)
    else $error("erase not marked running");
  a_no_double_erase: assert property ( // RQ3
    r_reg.req && r_reg.wr && r_reg.op == fse_pkg::OP_ERASE &&
    r_reg.bdata == fse_pkg::CMD_ESETUP |-> !r_reg.erasing)
    else $error("erase setup while erase pending");
  a_poll_in_sector: assert property ( // RQ12
    r_reg.req && !r_reg.wr && r_reg.op == fse_pkg::OP_POLL |-> r_reg.baddr == r_reg.sect)
    else $error("erase poll outside sector");
  a_fail_resets: assert property ( // RQ21
    r_reg.st == M_POLL2 && cy.done && cy.rdata[fse_pkg::BIT_TIMEOUT] && r_reg.chk &&
    cy.rdata[fse_pkg::BIT_TOGGLE] != r_reg.tog
    |=> r_reg.req && r_reg.wr && r_reg.bdata == fse_pkg::CMD_RESET ##[1:12] r_reg.done && r_reg.err)
    else $error("failed operation not reset");
  a_reset_not_busy: assert property ( // RQ23
    r_reg.req && r_reg.wr && r_reg.bdata == fse_pkg::CMD_RESET
    |-> !r_reg.erasing || r_reg.st == M_FAILRST)
    else $error("reset sent while erase running");
  a_susp_byte: assert property ( // RQ25
    r_reg.req && r_reg.wr && r_reg.op == fse_pkg::OP_SUSP
    |-> r_reg.bdata == fse_pkg::CMD_SUSP && r_reg.erasing && !r_reg.susp)
    else $error("bad suspend write");
  a_susp_settle: assert property ( // RQ7
    $rose(r_reg.susp) |-> $past(r_reg.st) == M_SUSPW && $past(r_reg.cnt) == SUSP_LAST)
    else $error("suspend reported early");

  c_prog_done: cover property (r_reg.done && r_reg.op == fse_pkg::OP_PROG && !r_reg.err);
  c_erase_done: cover property (r_reg.done && r_reg.op == fse_pkg::OP_POLL && !r_reg.err);
  c_susp_done: cover property ($rose(r_reg.susp));
  c_fail_reset: cover property (r_reg.st == M_FAILRST && cy.done);
endmodule

// ===== tb/fse_flash_model.sv
// behavioural flash device: command decode, embedded erase and program, status byte
`timescale 1ns/1ps
module fse_flash_model #(
  parameter int ERASE_TICKS = 300,
  parameter int PROG_TICKS = 3,
  parameter int PROT_PROG_TICKS = 20,
  parameter int PROT_ERASE_TICKS = 1000
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [19:0] i_addr,
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_dq_oe_n,
  output logic o_rb_oe_n
);
  logic [7:0] mem [16];
  logic [2:0] cyc = 3'h0;
  logic ers = 1'b0, sus = 1'b0, prg = 1'b0, bad = 1'b0, tmo = 1'b0, tog = 1'b0, tog2 = 1'b0;
  logic pp = 1'b0;
  logic [3:0] esec = 4'h0, pi = 4'h0;
  logic [7:0] pd = 8'h00;
  int eleft = 0, pleft = 0;
  wire [3:0] ix = {i_addr[17:16], i_addr[1:0]};
  wire hit = i_addr[19:16] == esec;
  // sector 3 stands write protected
  wire prot = i_addr[19:16] == 4'h3;
  wire run = (ers && !sus) || prg;
  initial for (int i = 0; i < 16; i++) mem[i] = (i / 4 == 1) ? 8'h00 : ((i / 4 == 3) ? 8'hC3 : 8'hFF);
  // ---------------------------------------------------------------
  // command decode on write strobe rise
  // ---------------------------------------------------------------
  always @(posedge i_we_n) if (!i_ce_n) begin
    if (ers && !sus) begin
      if (i_dq == 8'hB0) sus <= 1'b1;
    end else if (prg) begin
      if (tmo && i_dq == 8'hF0) prg <= 1'b0;
    end else begin
      cyc <= 3'h0;
      case (cyc)
        3'h0: if (i_dq == 8'hAA && i_addr == 20'h00555) cyc <= 3'h1;
          else if (sus && i_dq == 8'h30) sus <= 1'b0;
        3'h1: if (i_dq == 8'h55 && i_addr == 20'h002AA) cyc <= 3'h2;
        3'h2: if (i_addr == 20'h00555) cyc <= i_dq == 8'hA0 ? 3'h6 : (i_dq == 8'h80 ? 3'h3 : 3'h0);
        3'h3: if (i_dq == 8'hAA) cyc <= 3'h4;
        3'h4: if (i_dq == 8'h55) cyc <= 3'h5;
        3'h5: if (i_dq == 8'h30 && !sus) begin
          ers <= 1'b1;
          esec <= i_addr[19:16];
          eleft <= prot ? PROT_ERASE_TICKS : ERASE_TICKS;
        end
        3'h6: begin
          {pd, pi, prg, tmo, pp} <= {i_dq, ix, 2'b10, prot};
          bad <= |(i_dq & ~mem[ix]);
          pleft <= prot ? PROT_PROG_TICKS : PROG_TICKS;
        end
        default: cyc <= 3'h0;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // embedded algorithm timer, 100 ns a tick
  // ---------------------------------------------------------------
  always #100 begin
    if (prg && !tmo) begin
      pleft <= pleft - 1;
      if (pleft == 1 && bad) tmo <= 1'b1;
      if (pleft == 1 && !bad) {prg, mem[pi]} <= {1'b0, pp ? mem[pi] : pd};
    end else if (ers && !sus) begin
      eleft <= eleft - 1;
      if (eleft == 1) begin
        ers <= 1'b0;
        for (int i = 0; i < 16; i++) if (i / 4 == esec[1:0] && esec != 4'h3) mem[i] <= 8'hFF;
      end
    end
  end
  always @(negedge i_oe_n) if (!i_ce_n) begin
    if (run) tog <= !tog;
    if (ers && hit) tog2 <= !tog2;
  end
  always_comb begin
    o_dq = mem[ix];
    if (prg) o_dq = {~pd[7], tog, tmo, 5'h00};
    else if (ers && !sus) o_dq = {1'b0, tog, 3'h1, tog2, 2'h0};
    else if (ers && hit) o_dq = {1'b1, tog, 3'h0, tog2, 2'h0};
  end
  assign o_dq_oe_n = i_ce_n | i_oe_n;
  assign o_rb_oe_n = !run;
endmodule

// ===== tb/tb_top.sv
// self-checking bench: host sequencer driving the flash device model
`timescale 1ns/1ps
module tb_top;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_op_valid = 1'b0;
  fse_pkg::fse_op_t i_op = fse_pkg::OP_READ;
  logic [19:0] i_addr = 20'h00000;
  logic [7:0] i_wdata = 8'h00;
  logic o_op_ready, o_op_done, o_op_err, o_erase_active, o_erase_susp, o_dev_busy;
  logic ce_n, oe_n, we_n, dq_oe_n, dev_oe_n, rb_oe_n, er;
  logic [7:0] o_rdata, dq_out, dev_dq, dq_bus, rd, t, dq_last = 8'h00;
  logic [19:0] addr;
  int mismatches = 0, samples_checked = 0;
  fse_pkg::fse_op_t bad_ops [4] = '{fse_pkg::OP_ERASE, fse_pkg::OP_PROG, fse_pkg::OP_RESUME,
    fse_pkg::OP_RESET};
  // undriven bus shows the inverse of its last driven value
  assign dq_bus = !dq_oe_n ? dq_out : (!dev_oe_n ? dev_dq : ~dq_last);
  always @(posedge i_mclk) if (!dq_oe_n || !dev_oe_n) dq_last <= dq_bus;
  always #10 i_mclk = ~i_mclk;
  fse_host i_fse_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_op_ready(o_op_ready), .o_op_done(o_op_done),
    .o_op_err(o_op_err), .o_rdata(o_rdata), .o_erase_active(o_erase_active),
    .o_erase_susp(o_erase_susp), .o_dev_busy(o_dev_busy), .i_ready_busy_n(rb_oe_n),
    .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_dq_out(dq_out),
    .o_dq_oe_n(dq_oe_n), .i_dq(dq_bus));
  fse_flash_model i_fse_flash_model (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
    .i_addr(addr), .i_dq(dq_bus), .o_dq(dev_dq), .o_dq_oe_n(dev_oe_n), .o_rb_oe_n(rb_oe_n));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input fse_pkg::fse_op_t o, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_op_valid <= 1'b1;
    i_op <= o;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    do @(posedge i_mclk); while (o_op_done !== 1'b1 && ++n < 8000);
    if (n >= 8000) mismatches++;
    rd = o_rdata;
    er = o_op_err;
  endtask
  task automatic settle;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    chk({o_op_ready, o_dev_busy, ce_n, dq_oe_n}, 8'h0B);
    op(fse_pkg::OP_READ, 20'h10000, 8'h00);
    chk(rd, 8'h00);
    op(fse_pkg::OP_PROG, 20'h00001, 8'h5A);
    chk({7'h00, er}, 8'h00);
    op(fse_pkg::OP_PROG, 20'h00001, 8'hFF);
    chk({7'h00, er}, 8'h01);
    op(fse_pkg::OP_READ, 20'h00001, 8'h00);
    chk(rd, 8'h5A);
    op(fse_pkg::OP_ERASE, 20'h10000, 8'h00);
    settle;
    chk({o_erase_active, o_dev_busy, er}, 8'h06);
    op(fse_pkg::OP_READ, 20'h10000, 8'h00);
    chk(rd & 8'hA8, 8'h08);
    t = rd;
    op(fse_pkg::OP_READ, 20'h10000, 8'h00);
    chk((rd ^ t) & 8'h44, 8'h44);
    foreach (bad_ops[i]) begin
      op(bad_ops[i], 20'h00002, 8'h00);
      chk({7'h00, er}, 8'h01);
    end
    op(fse_pkg::OP_SUSP, 20'hABCDE, 8'h00);
    settle;
    chk({o_erase_susp, o_dev_busy, er}, 8'h04);
    op(fse_pkg::OP_READ, 20'h00001, 8'h00);
    chk(rd, 8'h5A);
    op(fse_pkg::OP_PROG, 20'h00002, 8'h3C);
    op(fse_pkg::OP_READ, 20'h00002, 8'h00);
    chk(rd, 8'h3C);
    op(fse_pkg::OP_READ, 20'h10001, 8'h00);
    t = rd;
    op(fse_pkg::OP_READ, 20'h10001, 8'h00);
    chk({rd[7], 7'h00} | ((rd ^ t) & 8'h44), 8'h84);
    op(fse_pkg::OP_RESUME, 20'h54321, 8'h00);
    settle;
    chk({o_erase_susp, o_dev_busy, er}, 8'h02);
    op(fse_pkg::OP_RESUME, 20'h00000, 8'h00);
    chk({7'h00, er}, 8'h01);
    op(fse_pkg::OP_SUSP, 20'h00000, 8'h00);
    chk({7'h00, er}, 8'h00);
    op(fse_pkg::OP_RESUME, 20'h00000, 8'h00);
    op(fse_pkg::OP_POLL, 20'h10000, 8'h00);
    settle;
    chk({o_erase_active, o_dev_busy, er}, 8'h00);
    op(fse_pkg::OP_READ, 20'h10002, 8'h00);
    chk(rd, 8'hFF);
    op(fse_pkg::OP_PROG, 20'h30001, 8'h00);
    chk({7'h00, er}, 8'h00);
    op(fse_pkg::OP_READ, 20'h30001, 8'h00);
    chk(rd, 8'hC3);
    op(fse_pkg::OP_ERASE, 20'h30000, 8'h00);
    op(fse_pkg::OP_POLL, 20'h30000, 8'h00);
    chk({7'h00, er}, 8'h00);
    op(fse_pkg::OP_READ, 20'h30001, 8'h00);
    chk(rd, 8'hC3);
    op(fse_pkg::OP_RESET, 20'h00000, 8'h00);
    chk({7'h00, er}, 8'h00);
    wrap_up;
  end
  initial begin
    #400000;
    mismatches++;
    wrap_up;
  end
endmodule
